// ==== logic/fibf_emitter.sv ====
// fast info block emitter: group fifo, block packer, check word, block numbering
// Functional notes
// - block is 256 bits, data then check word
// - full 30-byte field: no marker, no padding
// - 29 useful bytes: marker in last byte
// - under 29 bytes: marker then zero padding
// - empty block starts with marker, rest padding
// - end marker is header 0xFF, no data
// - padding bytes are all zero
// - 16-bit check word, poly x16+x12+x5+1
// - check register preset to all ones
// - emitter sends inverted check word
// - type field decode, type 7 reserved
// - length 1..29 valid, others reserved
// - never split a group across blocks
// - receiver skips unknown group types by length
// - receiver discards the rest of the block on parse error
// - receiver flags set must-be-zero bits
// - emitter drives reserved bits to zero
// - twelve blocks, four interleaved frames per frame
// - blocks grouped by three per interleaved frame
// - packer takes groups greedily in arrival order
`timescale 1ns/1ps
`default_nettype none
`include "fibf_regs.svh"

// ----------------------------------------------------------------------------
// group fifo
// ----------------------------------------------------------------------------
module fibf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = `FIBF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic room_reg;
  logic push;
  logic pull;

  assign push = in_valid_i && room_reg;
  assign pull = out_ready_i && (cnt_reg != '0);
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pull);
  assign in_ready_o = room_reg;
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];

  // storage, no reset needed
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_reg] <= in_data_i;
  end

  // pointers and fill level; room is a flop so the source sees clean back-pressure
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      room_reg <= 1'b1;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pull)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_next;
      room_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end
endmodule // fibf_fifo

// ----------------------------------------------------------------------------
// block emitter
// ----------------------------------------------------------------------------
module fibf_emitter #(
  parameter int FIFO_DEPTH = `FIBF_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // group input, header byte first, last on final byte
  input wire logic grp_valid_i,
  input wire fibf_pkg::fibf_byte_t grp_data_i,
  input wire logic grp_last_i,
  output logic grp_ready_o,
  // status
  output logic drop_o,
  output fibf_pkg::fibf_cif_t cif_o,
  // link
  fibf_link_if.emitter link
);
  import fibf_pkg::*;

  typedef enum logic [2:0] {S_HDR, S_BODY, S_DROP, S_PAD, S_CRC_LO} fibf_est_t;
  fibf_est_t state_reg;
  fibf_est_t state_next;
  logic [4:0] pos_reg;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [15:0] crc_reg;
  fibf_blk_t blk_reg;
  logic first_reg;
  logic rfu_grp_reg;
  logic lv_reg;
  fibf_byte_t ld_reg;
  logic lsob_reg;
  fibf_blk_t lblk_reg;
  logic drop_reg;
  fibf_cif_t cif_reg;
  logic fq_valid;
  logic fq_pop;
  logic [8:0] fq_data;
  fibf_byte_t fq_byte;
  logic fq_last;
  logic adv;
  logic emit;
  fibf_byte_t emit_data;
  logic drop_pulse;
  logic fits;

  // groups wait here; a stalled link fills it and stops the source
  fibf_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(grp_valid_i),
    .in_data_i({grp_last_i, grp_data_i}),
    .in_ready_o(grp_ready_o),
    .out_valid_o(fq_valid),
    .out_data_o(fq_data),
    .out_ready_i(fq_pop)
  );

  assign fq_byte = fq_data[7:0];
  assign fq_last = fq_data[8];
  // output stage may load when empty or taken
  assign adv = !lv_reg || link.ready;
  // header plus its data must fit in what is left of the field
  assign fits = ({1'b0, fq_byte[`FIBF_LEN_MSB:`FIBF_LEN_LSB]} + 6'd1) <= (`FIBF_DATA_BYTES - {1'b0, pos_reg});

  // next byte selection; groups taken greedily in arrival order
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    emit = 1'b0;
    emit_data = `FIBF_PAD_BYTE;
    fq_pop = 1'b0;
    drop_pulse = 1'b0;
    if (adv)
    begin
      case (state_reg)
        S_HDR:
        begin
          if (pos_reg == `FIBF_CRC_HI_POS)
          begin
            emit = 1'b1;
            emit_data = ~crc_reg[15:8];
            state_next = S_CRC_LO;
          end
          else if (fq_valid && !fibf_hdr_legal(fq_byte))
          begin
            // reserved length or type 7 cannot be framed: discard to its last byte
            fq_pop = 1'b1;
            drop_pulse = 1'b1;
            state_next = fq_last ? S_HDR : S_DROP;
          end
          else if (fq_valid && fits)
          begin
            emit = 1'b1;
            emit_data = fq_byte;
            fq_pop = 1'b1;
            cnt_next = fq_byte[`FIBF_LEN_MSB:`FIBF_LEN_LSB];
            state_next = S_BODY;
          end
          else
          begin
            // no group or next one does not fit: close with the marker
            emit = 1'b1;
            emit_data = `FIBF_END_MARKER;
            state_next = S_PAD;
          end
        end
        S_BODY:
        begin
          if (fq_valid)
          begin
            emit = 1'b1;
            emit_data = fq_byte;
            if (first_reg && rfu_grp_reg)
              emit_data[`FIBF_RFU_BIT] = 1'b0;
            fq_pop = 1'b1;
            cnt_next = cnt_reg - 5'd1;
            if (cnt_reg == 5'd1)
              state_next = S_HDR;
          end
        end
        S_DROP:
        begin
          fq_pop = fq_valid;
          if (fq_valid && fq_last)
            state_next = S_HDR;
        end
        S_PAD:
        begin
          emit = 1'b1;
          if (pos_reg == `FIBF_CRC_HI_POS)
          begin
            emit_data = ~crc_reg[15:8];
            state_next = S_CRC_LO;
          end
          else
            emit_data = `FIBF_PAD_BYTE;
        end
        S_CRC_LO:
        begin
          emit = 1'b1;
          emit_data = ~crc_reg[7:0];
          state_next = S_HDR;
        end
        default:
          state_next = S_HDR;
      endcase
    end
  end

  // packer state, byte position and group bookkeeping
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= S_HDR;
      cnt_reg <= 5'd0;
      pos_reg <= 5'd0;
      first_reg <= 1'b0;
      rfu_grp_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // 32 bytes per block, position wraps to zero after the low check byte
      if (emit)
        pos_reg <= pos_reg + 5'd1;
      if (emit && state_reg == S_HDR)
      begin
        first_reg <= 1'b1;
        rfu_grp_reg <= (fq_byte[7:5] == FIBF_GT_LABEL1) || (fq_byte[7:5] == FIBF_GT_LABEL2);
      end
      else if (emit)
        first_reg <= 1'b0;
    end
  end

  // check word over the 30 data bytes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      crc_reg <= `FIBF_CRC_INIT;
    else if (emit && state_reg == S_CRC_LO)
      crc_reg <= `FIBF_CRC_INIT;
    else if (emit && pos_reg <= `FIBF_DATA_LAST)
      crc_reg <= fibf_crc_byte(crc_reg, emit_data);
  end

  // block number inside the transmission frame
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk_reg <= 4'd0;
      cif_reg <= 2'd0;
    end
    else
    begin
      if (emit && state_reg == S_CRC_LO)
        blk_reg <= (blk_reg == `FIBF_BLOCKS_PER_FRAME - 4'd1) ? 4'd0 : blk_reg + 4'd1;
      cif_reg <= fibf_cif_of(blk_reg);
    end
  end

  // registered link output stage
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lv_reg <= 1'b0;
      ld_reg <= `FIBF_PAD_BYTE;
      lsob_reg <= 1'b0;
      lblk_reg <= 4'd0;
      drop_reg <= 1'b0;
    end
    else
    begin
      drop_reg <= drop_pulse;
      if (adv)
      begin
        lv_reg <= emit;
        if (emit)
        begin
          ld_reg <= emit_data;
          lsob_reg <= (pos_reg == 5'd0);
          lblk_reg <= blk_reg;
        end
      end
    end
  end

  assign link.valid = lv_reg;
  assign link.data = ld_reg;
  assign link.sob = lsob_reg;
  assign link.blk = lblk_reg;
  assign drop_o = drop_reg;
  assign cif_o = cif_reg;
endmodule // fibf_emitter
`default_nettype wire

// ==== logic/fibf_receiver.sv ====
// fast info block receiver: block capture, check word test, group parser
`timescale 1ns/1ps
`default_nettype none
`include "fibf_regs.svh"
module fibf_receiver (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  fibf_link_if.receiver link,
  // group output, header byte first
  output logic grp_valid_o,
  output fibf_pkg::fibf_byte_t grp_data_o,
  output logic grp_first_o,
  output logic grp_last_o,
  output fibf_pkg::fibf_grp_type_t grp_type_o,
  output fibf_pkg::fibf_cif_t grp_cif_o,
  // status pulses
  output logic block_ok_o,
  output logic crc_err_o,
  output logic parse_err_o,
  output logic new_feature_o
);
  import fibf_pkg::*;

  typedef enum logic [1:0] {R_COLLECT, R_HDR, R_DATA} fibf_rst_t;
  fibf_rst_t state_reg;
  fibf_byte_t buf_mem [32];
  logic [4:0] wpos_reg;
  logic [4:0] rpos_reg;
  logic [4:0] cnt_reg;
  logic [15:0] crc_reg;
  logic hi_ok_reg;
  logic rdy_reg;
  fibf_blk_t blk_reg;
  logic take;
  logic [4:0] wp;
  fibf_byte_t hdr;
  logic [4:0] hlen;
  logic [5:0] room;

  assign take = link.valid && rdy_reg;
  // start of block resynchronises the byte position
  assign wp = link.sob ? 5'd0 : wpos_reg;
  assign hdr = buf_mem[rpos_reg];
  assign hlen = hdr[`FIBF_LEN_MSB:`FIBF_LEN_LSB];
  assign room = `FIBF_DATA_BYTES - {1'b0, rpos_reg};
  assign link.ready = rdy_reg;

  // data field store; whole block held until the check word is known
  always_ff @(posedge clk_i)
  begin
    if (take && wp <= `FIBF_DATA_LAST)
      buf_mem[wp] <= link.data;
  end

  // capture, check and parse
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg <= R_COLLECT;
      wpos_reg <= 5'd0;
      rpos_reg <= 5'd0;
      cnt_reg <= 5'd0;
      crc_reg <= `FIBF_CRC_INIT;
      hi_ok_reg <= 1'b0;
      rdy_reg <= 1'b1;
      blk_reg <= 4'd0;
      grp_valid_o <= 1'b0;
      grp_data_o <= 8'h00;
      grp_first_o <= 1'b0;
      grp_last_o <= 1'b0;
      grp_type_o <= FIBF_GT_CONFIG;
      grp_cif_o <= 2'd0;
      block_ok_o <= 1'b0;
      crc_err_o <= 1'b0;
      parse_err_o <= 1'b0;
      new_feature_o <= 1'b0;
    end
    else
    begin
      grp_valid_o <= 1'b0;
      grp_first_o <= 1'b0;
      grp_last_o <= 1'b0;
      block_ok_o <= 1'b0;
      crc_err_o <= 1'b0;
      parse_err_o <= 1'b0;
      new_feature_o <= 1'b0;
      case (state_reg)
        R_COLLECT:
        begin
          if (take)
          begin
            wpos_reg <= wp + 5'd1;
            if (wp <= `FIBF_DATA_LAST)
              crc_reg <= fibf_crc_byte((wp == 5'd0) ? `FIBF_CRC_INIT : crc_reg, link.data);
            else if (wp == `FIBF_CRC_HI_POS)
              hi_ok_reg <= (link.data == ~crc_reg[15:8]);
            else if (hi_ok_reg && link.data == ~crc_reg[7:0])
            begin
              // good block: stop the link while it is parsed
              rdy_reg <= 1'b0;
              rpos_reg <= 5'd0;
              blk_reg <= link.blk;
              block_ok_o <= 1'b1;
              state_reg <= R_HDR;
            end
            else
              crc_err_o <= 1'b1;
          end
        end
        R_HDR:
        begin
          if (rpos_reg == `FIBF_CRC_HI_POS || hdr == `FIBF_END_MARKER)
          begin
            rdy_reg <= 1'b1;
            state_reg <= R_COLLECT;
          end
          else if (!fibf_hdr_legal(hdr) || ({1'b0, hlen} + 6'd1) > room)
          begin
            // next group cannot be located: rest of the block is lost
            parse_err_o <= 1'b1;
            rdy_reg <= 1'b1;
            state_reg <= R_COLLECT;
          end
          else if (hdr[7:5] == FIBF_GT_RES3 || hdr[7:5] == FIBF_GT_RES4 || hdr[7:5] == FIBF_GT_RES5)
            rpos_reg <= rpos_reg + hlen + 5'd1;
          else if ((hdr[7:5] == FIBF_GT_LABEL1 || hdr[7:5] == FIBF_GT_LABEL2) &&
                   buf_mem[rpos_reg + 5'd1][`FIBF_RFU_BIT])
          begin
            new_feature_o <= 1'b1;
            rpos_reg <= rpos_reg + hlen + 5'd1;
          end
          else
          begin
            grp_valid_o <= 1'b1;
            grp_first_o <= 1'b1;
            grp_data_o <= hdr;
            grp_type_o <= fibf_grp_type_t'(hdr[7:5]);
            grp_cif_o <= fibf_cif_of(blk_reg);
            cnt_reg <= hlen;
            rpos_reg <= rpos_reg + 5'd1;
            state_reg <= R_DATA;
          end
        end
        R_DATA:
        begin
          grp_valid_o <= 1'b1;
          grp_data_o <= hdr;
          grp_last_o <= (cnt_reg == 5'd1);
          cnt_reg <= cnt_reg - 5'd1;
          rpos_reg <= rpos_reg + 5'd1;
          if (cnt_reg == 5'd1)
            state_reg <= R_HDR;
        end
        default:
          state_reg <= R_COLLECT;
      endcase
    end
  end
endmodule // fibf_receiver
`default_nettype wire

// ==== shared/fibf_link_if.sv ====
// byte link between block emitter and block receiver
`timescale 1ns/1ps
`default_nettype none
interface fibf_link_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  logic sob;
  logic [3:0] blk;
  modport emitter (output valid, output data, output sob, output blk, input ready);
  modport receiver (input valid, input data, input sob, input blk, output ready);
endinterface
`default_nettype wire

// ==== shared/fibf_pkg.sv ====
// types and shared functions of the fast info block framer
`include "fibf_regs.svh"
package fibf_pkg;
  typedef logic [7:0] fibf_byte_t;
  typedef logic [3:0] fibf_blk_t;
  typedef logic [1:0] fibf_cif_t;
  typedef enum logic [2:0] {
    FIBF_GT_CONFIG = 3'h0,
    FIBF_GT_LABEL1 = 3'h1,
    FIBF_GT_LABEL2 = 3'h2,
    FIBF_GT_RES3 = 3'h3,
    FIBF_GT_RES4 = 3'h4,
    FIBF_GT_RES5 = 3'h5,
    FIBF_GT_CA = 3'h6,
    FIBF_GT_RES7 = 3'h7
  } fibf_grp_type_t;

  // one byte into the check word, msb first
  function automatic logic [15:0] fibf_crc_byte(input logic [15:0] c, input fibf_byte_t d);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      fb = r[15] ^ d[i];
      r = {r[14:0], 1'b0};
      if (fb)
        r = r ^ `FIBF_CRC_POLY;
    end
    return r;
  endfunction

  // header is usable: length 1..29 and not the reserved type 7
  function automatic logic fibf_hdr_legal(input fibf_byte_t h);
    return (h[`FIBF_LEN_MSB:`FIBF_LEN_LSB] >= `FIBF_LEN_MIN) &&
           (h[`FIBF_LEN_MSB:`FIBF_LEN_LSB] <= `FIBF_LEN_MAX) &&
           (h[`FIBF_TYPE_MSB:`FIBF_TYPE_LSB] != `FIBF_TYPE_END);
  endfunction

  // interleaved frame that a block of the transmission frame describes
  function automatic fibf_cif_t fibf_cif_of(input fibf_blk_t b);
    fibf_blk_t q;
    q = b / `FIBF_BLOCKS_PER_CIF;
    return q[1:0];
  endfunction
endpackage

// ==== shared/fibf_regs.svh ====
// constants of the fast info block framer: sizes, codes, field positions, timing
`ifndef FIBF_REGS_SVH
`define FIBF_REGS_SVH
// ----------------------------------------------------------------------------
// block layout
// ----------------------------------------------------------------------------
`define FIBF_BLOCK_BITS 9'd256
`define FIBF_DATA_BYTES 6'd30
`define FIBF_DATA_LAST 5'd29
`define FIBF_CRC_HI_POS 5'd30
`define FIBF_CRC_LO_POS 5'd31
`define FIBF_END_MARKER 8'hFF
`define FIBF_PAD_BYTE 8'h00
// ----------------------------------------------------------------------------
// group header fields
// ----------------------------------------------------------------------------
`define FIBF_TYPE_MSB 7
`define FIBF_TYPE_LSB 5
`define FIBF_LEN_MSB 4
`define FIBF_LEN_LSB 0
`define FIBF_LEN_MIN 5'h01
`define FIBF_LEN_MAX 5'h1D
`define FIBF_TYPE_END 3'h7
`define FIBF_RFU_BIT 3
// ----------------------------------------------------------------------------
// check word
// ----------------------------------------------------------------------------
`define FIBF_CRC_POLY 16'h1021
`define FIBF_CRC_INIT 16'hFFFF
// ----------------------------------------------------------------------------
// transmission frame timing
// ----------------------------------------------------------------------------
`define FIBF_FRAME_MS 96
`define FIBF_BLOCKS_PER_FRAME 4'd12
`define FIBF_BLOCKS_PER_CIF 4'd3
`define FIBF_CIFS_PER_FRAME 3'd4
`define FIBF_FIFO_DEPTH 32
`endif

// ==== sim/fast_info_block_framer_tb.sv ====
// testbench: emitter and receiver face to face, second receiver fed by hand
`timescale 1ns/1ps
`default_nettype none
module fast_info_block_framer_tb;
  import fibf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic g_valid = 1'b0;
  logic [7:0] g_data = 8'h00;
  logic g_last = 1'b0;
  logic g_ready, drop, r_valid, r_first, r_last, r_ok, r_crc, r_pe, r_nf;
  logic q_valid, q_crc, q_pe, q_nf;
  logic [7:0] r_data, q_data;
  fibf_grp_type_t r_type;
  fibf_cif_t r_cif, e_cif;
  int miscompares = 0;
  int checks_done = 0;
  int n_drop = 0, n_full = 0, n_ok = 0, n_bad1 = 0, n_crc2 = 0, n_pe2 = 0, n_nf2 = 0;
  logic [3:0] blk_taken = 4'hb; // first block start steps it to 0
  logic [15:0] got1[$], exp1[$], got2[$];
  fibf_link_if lnk();
  fibf_link_if lnk2();
  // ---------------------------------------------------------------------------
  // design, checker, second receiver
  // ---------------------------------------------------------------------------
  // small fifo so that a stalled receiver fills it quickly
  fibf_emitter #(.FIFO_DEPTH(4)) i_fibf_emitter (.clk_i(clk_i), .rst_i(rst_i), .grp_valid_i(g_valid),
    .grp_data_i(g_data), .grp_last_i(g_last), .grp_ready_o(g_ready), .drop_o(drop), .cif_o(e_cif), .link(lnk));
  fibf_receiver i_fibf_receiver (.clk_i(clk_i), .rst_i(rst_i), .link(lnk), .grp_valid_o(r_valid),
    .grp_data_o(r_data), .grp_first_o(r_first), .grp_last_o(r_last), .grp_type_o(r_type), .grp_cif_o(r_cif),
    .block_ok_o(r_ok), .crc_err_o(r_crc), .parse_err_o(r_pe), .new_feature_o(r_nf));
  fibf_link_monitor i_fibf_link_monitor (.clk_i(clk_i), .rst_i(rst_i), .valid(lnk.valid), .ready(lnk.ready),
    .data(lnk.data), .sob(lnk.sob), .blk(lnk.blk));
  fibf_receiver i_fibf_receiver_2 (.clk_i(clk_i), .rst_i(rst_i), .link(lnk2), .grp_valid_o(q_valid),
    .grp_data_o(q_data), .grp_first_o(), .grp_last_o(), .grp_type_o(), .grp_cif_o(), .block_ok_o(),
    .crc_err_o(q_crc), .parse_err_o(q_pe), .new_feature_o(q_nf));
  always #2 clk_i = ~clk_i;
  // collect outputs; cif is judged before the next block start is noted
  always @(posedge clk_i)
  begin
    if (r_valid === 1'b1 && r_first === 1'b1)
      chk(16'(r_cif), 16'(blk_taken / 4'h3));
    if (lnk.valid === 1'b1 && lnk.ready === 1'b1 && lnk.sob === 1'b1)
    begin
      blk_taken = (blk_taken == 4'hb) ? 4'h0 : blk_taken + 4'h1;
      chk(16'(lnk.blk), 16'(blk_taken));
      chk(16'(e_cif), 16'(blk_taken / 4'h3));
    end
    if (r_valid === 1'b1)
      got1.push_back({3'b000, r_first, r_last, r_first ? 3'(r_type) : 3'h0, r_data});
    if (q_valid === 1'b1)
      got2.push_back(16'(q_data));
    n_drop += (drop !== 1'b0);
    n_ok += (r_ok !== 1'b0);
    n_bad1 += (r_crc !== 1'b0 || r_pe !== 1'b0 || r_nf !== 1'b0);
    n_crc2 += (q_crc !== 1'b0);
    n_pe2 += (q_pe !== 1'b0);
    n_nf2 += (q_nf !== 1'b0);
  end
  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one group byte, held until the fifo takes it; refusals are counted
  task automatic push(input logic [7:0] d, input logic last);
    g_valid <= 1'b1;
    g_data <= d;
    g_last <= last;
    do
    begin
      @(posedge clk_i);
      n_full += (g_ready !== 1'b1);
    end
    while (g_ready !== 1'b1);
    #1;
  endtask
  // whole group; expected receiver bytes are queued for known legal types
  task automatic grp(input logic [7:0] h, input int n);
    logic [7:0] d;
    logic keep;
    keep = h[4:0] >= 5'h01 && h[4:0] <= 5'h1d && !(h[7:5] inside {3'h3, 3'h4, 3'h5, 3'h7});
    push(h, n == 0);
    if (keep)
      exp1.push_back({3'b000, 2'b10, h[7:5], h});
    for (int i = 0; i < n; i++)
    begin
      d = (i == 0) ? 8'h4c : 8'(8'h10 + i);
      push(d, i == n - 1);
      if (keep)
        exp1.push_back({3'b000, 1'b0, i == n - 1, 3'h0, (i == 0 && h[7:5] inside {3'h1, 3'h2}) ? 8'h44 : d});
    end
    g_valid <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  // wait for the expected bytes, then compare them all
  task automatic drain();
    int k = 0;
    while (got1.size() < exp1.size() && k < 3000)
    begin
      @(posedge clk_i);
      k++;
    end
    repeat (100) @(posedge clk_i);
    #1;
    chk(16'(got1.size()), 16'(exp1.size()));
    foreach (exp1[i])
      if (i < got1.size())
        chk(got1[i], exp1[i]);
    got1 = {};
    exp1 = {};
  endtask
  // hand-made block to the second receiver; bad flips a check bit
  task automatic send2(input logic [7:0] f [30], input logic bad);
    logic [15:0] c = 16'hffff;
    for (int i = 0; i < 32; i++)
    begin
      lnk2.valid <= 1'b1;
      lnk2.sob <= (i == 0);
      lnk2.data <= (i < 30) ? f[i] : (i == 30) ? ~c[15:8] : ~c[7:0] ^ {7'h00, bad};
      if (i < 30)
        c = i_fibf_link_monitor.step(c, f[i]);
      do @(posedge clk_i); while (lnk2.ready !== 1'b1);
      #1;
    end
    lnk2.valid <= 1'b0;
    lnk2.data <= ~lnk2.data;
    @(posedge clk_i);
    #1;
  endtask
  // ---------------------------------------------------------------------------
  // scenarios and run control
  // ---------------------------------------------------------------------------
  task automatic s_far();
    logic [7:0] f [30] = '{default: 8'h00};
    f[0:5] = '{8'h82, 8'h11, 8'h12, 8'h01, 8'h5a, 8'hff};
    send2(f, 1'b0);
    send2(f, 1'b1);
    f[0:5] = '{8'h22, 8'h08, 8'h00, 8'h01, 8'h77, 8'hff};
    send2(f, 1'b0);
    f[0] = 8'h1f;
    send2(f, 1'b0);
    repeat (80) @(posedge clk_i);
    chk(16'(got2.size()), 16'h0004);
    chk({got2[0][7:0], got2[1][7:0]}, 16'h015a);
    chk({got2[2][7:0], got2[3][7:0]}, 16'h0177);
    chk(16'(n_crc2), 16'h0001);
    chk(16'(n_nf2), 16'h0001);
    chk(16'(n_pe2), 16'h0001);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    int k;
    lnk2.valid = 1'b0;
    lnk2.sob = 1'b0;
    lnk2.data = 8'h00;
    lnk2.blk = 4'h0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    grp(8'h1d, 29);
    grp(8'h1c, 28);
    grp(8'h02, 2);
    drain();
    chk(16'(n_full > 0), 16'h0001);
    for (int t = 0; t < 7; t++)
      grp({3'(t), 5'h03}, 3);
    drain();
    chk(16'(n_bad1), 16'h0000);
    n_drop = 0;
    grp(8'h00, 0);
    grp(8'h1e, 30);
    grp(8'h1f, 31);
    grp(8'he5, 5);
    grp(8'h01, 1);
    drain();
    chk(16'(n_drop), 16'h0004);
    grp(8'h14, 20);
    grp(8'h14, 20);
    grp(8'h09, 9);
    drain();
    k = n_ok;
    repeat (500) @(posedge clk_i);
    chk(16'(n_ok - k >= 12), 16'h0001);
    drain();
    s_far();
    wrap_up();
  end
  // watchdog well past the few thousand cycles the run needs
  initial
  begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule // fast_info_block_framer_tb
`default_nettype wire

// ==== sim/fibf_link_monitor.sv ====
// link checker of the fast info block framer
`timescale 1ns/1ps
`default_nettype none
module fibf_link_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link
  input wire logic valid,
  input wire logic ready,
  input wire logic [7:0] data,
  input wire logic sob,
  input wire logic [3:0] blk
);
  logic [4:0] pos_reg;
  logic [5:0] hdr_reg;
  logic pad_reg;
  logic [15:0] crc_reg;
  logic [3:0] blk_reg;
  logic seen_reg;
  wire logic take = valid && ready;
  wire logic [5:0] len = {1'b0, data[4:0]};
  // own check word step, kept apart from the design's so a shared slip shows
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ 16'h1021) : {c[14:0], 1'b0};
    return c;
  endfunction
  // ---------------------------------------------------------------------------
  // wire tracking: byte position, next header, padding zone, check word
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pos_reg <= 5'h00;
    else if (take)
      pos_reg <= pos_reg + 5'h01;
  end
  // a header decides where the next one sits; the marker opens the padding
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hdr_reg <= 6'h00;
      pad_reg <= 1'b0;
    end
    else if (take && pos_reg == 5'h1f)
    begin
      hdr_reg <= 6'h00;
      pad_reg <= 1'b0;
    end
    else if (take && pos_reg < 5'h1e && !pad_reg && {1'b0, pos_reg} == hdr_reg)
    begin
      if (data == 8'hff)
        pad_reg <= 1'b1;
      else
        hdr_reg <= hdr_reg + 6'h01 + len;
    end
  end
  // check word over the data field, preset at byte 0
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      crc_reg <= 16'hffff;
    else if (take && pos_reg < 5'h1e)
      crc_reg <= step((pos_reg == 5'h00) ? 16'hffff : crc_reg, data);
  end
  // block number of the block on the wire
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      blk_reg <= 4'h0;
      seen_reg <= 1'b0;
    end
    else if (take && sob)
    begin
      blk_reg <= blk;
      seen_reg <= 1'b1;
    end
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_hold;
    valid && !ready |=> valid && $stable(data) && $stable(sob) && $stable(blk);
  endproperty
  a_hold: assert property (p_hold) else $error("link byte changed while stalled");
  property p_sob;
    valid |-> (sob == (pos_reg == 5'h00));
  endproperty
  a_sob: assert property (p_sob) else $error("block start not every 32 bytes");
  property p_blk_range;
    valid |-> blk <= 4'hb;
  endproperty
  a_blk_range: assert property (p_blk_range) else $error("block number above 11");
  property p_blk_step;
    take && sob && seen_reg |-> blk == ((blk_reg == 4'hb) ? 4'h0 : blk_reg + 4'h1);
  endproperty
  a_blk_step: assert property (p_blk_step) else $error("block number did not step");
  property p_blk_hold;
    valid && !sob |-> blk == blk_reg;
  endproperty
  a_blk_hold: assert property (p_blk_hold) else $error("block number moved in block");
  property p_crc_hi;
    valid && pos_reg == 5'h1e |-> data == ~crc_reg[15:8];
  endproperty
  a_crc_hi: assert property (p_crc_hi) else $error("check high byte wrong");
  property p_crc_lo;
    valid && pos_reg == 5'h1f |-> data == ~crc_reg[7:0];
  endproperty
  a_crc_lo: assert property (p_crc_lo) else $error("check low byte wrong");
  property p_pad;
    valid && pad_reg && pos_reg < 5'h1e |-> data == 8'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("padding byte not zero");
  property p_hdr;
    valid && !pad_reg && {1'b0, pos_reg} == hdr_reg && pos_reg < 5'h1e && data != 8'hff
      |-> len >= 6'h01 && len <= 6'h1d && data[7:5] != 3'h7 && hdr_reg + 6'h01 + len <= 6'h1e;
  endproperty
  a_hdr: assert property (p_hdr) else $error("illegal or split group");
  property p_marker;
    valid && pos_reg == 5'h1e |-> pad_reg || hdr_reg == 6'h1e;
  endproperty
  a_marker: assert property (p_marker) else $error("short field without marker");
  property p_ready;
    take && pos_reg == 5'h1f |=> !ready;
  endproperty
  a_ready: assert property (p_ready) else $error("receiver kept taking after block");
endmodule // fibf_link_monitor
`default_nettype wire
